/* hw/vectored_interrupt_controller.sv */
`timescale 1ns/1ps
module vectored_interrupt_controller (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // apb slave
  input  wire logic [11:0]                 paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // request sources
  input  wire logic [ivc_pkg::NUM_SRC-1:0] srcReq,
  input  wire logic [ivc_pkg::NUM_EXT-1:0] extPin,
  input  wire logic [3:0]                  trapEvt,
  // cpu side
  input  wire logic                        cpuAck,
  input  wire logic                        cpuReturn,
  input  wire logic [3:0]                  returnLevel,
  output logic                             irqReq,
  output logic [6:0]                       irqVector,
  output logic [3:0]                       irqLevel,
  output logic [23:0]                      vectorAddr,
  output logic [3:0]                       cpuLevel
);
  import ivc_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic hitRange(input logic [11:0] a, input logic [11:0] base,
                                    input int n);
    return (a >= base) && (a < 12'(base + 12'(4 * n))) && (a[1:0] == 2'b00);
  endfunction

  function automatic int wordIdx(input logic [11:0] a, input logic [11:0] base);
    return int'(12'(a - base) >> 2);
  endfunction

  function automatic logic [23:0] tableAddr(input logic [6:0] vec, input logic alt);
    logic [23:0] addr;
    addr = 24'(DEFAULT_TABLE_BASE + {16'h0000, vec, 1'b0});
    if (alt) begin
      addr = 24'(addr + ALT_TABLE_OFFSET);
    end
    return addr;
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [FLAG_BITS-1:0]  flagQ;
  logic [FLAG_BITS-1:0]  flagD;
  logic [FLAG_BITS-1:0]  enableQ;
  logic [PRIO_BITS-1:0]  prioQ;
  logic [3:0]            trapQ;
  logic                  nestDisQ;
  logic                  altSelQ;
  logic [NUM_EXT-1:0]    edgePolQ;
  logic [2:0]            levelLowQ;
  logic                  levelTopQ;
  logic                  irqReqQ;
  logic [6:0]            vecNumQ;
  logic [3:0]            newLevelQ;
  logic [23:0]           vectorAddrQ;
  logic [31:0]           prdataQ;
  logic                  pslverrQ;
  logic [NUM_EXT-1:0]    extMetaQ;
  logic [NUM_EXT-1:0]    extSyncQ;
  logic [NUM_EXT-1:0]    extPrevQ;
  logic [2:0]            extWarmQ;

  logic                  wrEn;
  logic                  setupRd;
  logic [NUM_EXT-1:0]    extEdge;
  logic [FLAG_BITS-1:0]  setVec;
  logic [3:0]            curLevel;
  logic [NUM_VEC-1:0]    pendVec;
  logic [NUM_VEC*4-1:0]  lvlVec;
  logic                  win;
  logic [6:0]            winVec;
  logic [3:0]            winLevel;
  logic [31:0]           rdData;
  logic                  mapped;

  assign wrEn     = ce && psel && penable && pwrite;
  assign setupRd  = ce && psel && !penable;
  assign curLevel = {levelTopQ, levelLowQ};

  // ------------------------------------------------------------------
  // external inputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      extMetaQ <= '0;
      extSyncQ <= '0;
      extPrevQ <= '0;
      extWarmQ <= '0;
    end else if (ce) begin
      extMetaQ <= extPin;
      extSyncQ <= extMetaQ;
      extPrevQ <= extSyncQ;
      extWarmQ <= {extWarmQ[1:0], 1'b1};
    end
  end

  // rising or falling edge of the synchronised pin
  // a pin idling high would fake an edge after reset, so edges wait
  // until the chain is full; only an edge before the first sample after reset is lost
  assign extEdge = {NUM_EXT{extWarmQ[2]}} &
                   ((edgePolQ & extPrevQ & ~extSyncQ) |
                    (~edgePolQ & ~extPrevQ & extSyncQ));

  always_comb begin
    setVec           = {2'b00, srcReq};
    setVec[EXT0_SRC] = srcReq[EXT0_SRC] | extEdge[0];
    setVec[EXT1_SRC] = srcReq[EXT1_SRC] | extEdge[1];
    setVec[EXT2_SRC] = srcReq[EXT2_SRC] | extEdge[2];
  end

  // ------------------------------------------------------------------
  // request flags
  // ------------------------------------------------------------------
  // an event in the cycle of a software clear still lands
  always_comb begin
    flagD = flagQ;
    if (wrEn && hitRange(paddr, FLAG_BASE, FLAG_WORDS)) begin
      flagD[wordIdx(paddr, FLAG_BASE)*16 +: 16] = pwdata[15:0];
    end
    flagD = (flagD | setVec) & SRC_IMPL;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flagQ <= '0;
    end else if (ce) begin
      flagQ <= flagD;
    end
  end

  // ------------------------------------------------------------------
  // enables and priorities
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      enableQ <= '0;
    end else if (wrEn && hitRange(paddr, ENABLE_BASE, FLAG_WORDS)) begin
      enableQ[wordIdx(paddr, ENABLE_BASE)*16 +: 16] <=
        pwdata[15:0] & SRC_IMPL[wordIdx(paddr, ENABLE_BASE)*16 +: 16];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prioQ <= '0;
    end else if (wrEn && hitRange(paddr, PRIO_BASE, PRIO_WORDS)) begin
      prioQ[wordIdx(paddr, PRIO_BASE)*16 +: 16] <=
        pwdata[15:0] & PRIO_MASK[wordIdx(paddr, PRIO_BASE)*16 +: 16];
    end
  end

  // ------------------------------------------------------------------
  // control 1: nesting disable and trap status
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      nestDisQ <= 1'b0;
    end else if (wrEn && paddr == CTRL1_OFS) begin
      nestDisQ <= pwdata[CTRL1_NEST_BIT];
    end
  end

  // trap bits: osc, stack, address, math; hardware set beats a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      trapQ <= '0;
    end else if (ce) begin
      if (wrEn && paddr == CTRL1_OFS) begin
        trapQ <= pwdata[CTRL1_TRAP_LSB +: 4] | trapEvt;
      end else begin
        trapQ <= trapQ | trapEvt;
      end
    end
  end

  // ------------------------------------------------------------------
  // control 2: table select and edge polarity
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      altSelQ  <= 1'b0;
      edgePolQ <= '0;
    end else if (wrEn && paddr == CTRL2_OFS) begin
      altSelQ  <= pwdata[CTRL2_ALT_BIT];
      edgePolQ <= pwdata[CTRL2_EP_LSB +: NUM_EXT];
    end
  end

  // ------------------------------------------------------------------
  // cpu priority level
  // ------------------------------------------------------------------
  // cpu entry and return load the level regardless of nesting lock
  always_ff @(posedge clk) begin
    if (rst) begin
      levelLowQ <= LEVEL_RESET;
    end else if (ce) begin
      if (cpuAck && irqReqQ) begin
        levelLowQ <= newLevelQ[2:0];
      end else if (cpuReturn) begin
        levelLowQ <= returnLevel[2:0];
      end else if (wrEn && paddr == CPU_STATUS_OFS && !nestDisQ) begin
        levelLowQ <= pwdata[STATUS_LEVEL_LSB +: 3];
      end
    end
  end

  // software may only clear the top bit, so traps cannot be masked
  always_ff @(posedge clk) begin
    if (rst) begin
      levelTopQ <= 1'b0;
    end else if (ce) begin
      if (cpuAck && irqReqQ) begin
        levelTopQ <= newLevelQ[3];
      end else if (cpuReturn) begin
        levelTopQ <= returnLevel[3];
      end else if (wrEn && paddr == CORE_CTRL_OFS && !pwdata[CORE_TOP_BIT]) begin
        levelTopQ <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // candidate build
  // ------------------------------------------------------------------
  always_comb begin
    pendVec = '0;
    lvlVec  = '0;
    // traps: no enable, fixed level from vector number
    pendVec[VEC_CLOCK_FAIL] = trapQ[0];
    pendVec[VEC_ADDRESS]    = trapQ[2];
    pendVec[VEC_STACK]      = trapQ[1];
    pendVec[VEC_MATH]       = trapQ[3];
    for (int t = 1; t < NUM_TRAP; t++) begin
      lvlVec[t*4 +: 4] = 4'(TRAP_LEVEL_TOP - 4'(t));
      pendVec[t]       = pendVec[t] && (4'(TRAP_LEVEL_TOP - 4'(t)) > curLevel);
    end
    for (int k = 0; k < NUM_SRC; k++) begin
      lvlVec[(k+NUM_TRAP)*4 +: 4] = {1'b0, prioQ[k*PRIO_FIELD_STEP +: 3]};
      pendVec[k+NUM_TRAP] = flagQ[k] && enableQ[k] && !levelTopQ &&
                            ({1'b0, prioQ[k*PRIO_FIELD_STEP +: 3]} > curLevel);
    end
  end

  ivc_resolve u_resolve (
    .pend     (pendVec),
    .lvl      (lvlVec),
    .win      (win),
    .winVec   (winVec),
    .winLevel (winLevel)
  );

  // ------------------------------------------------------------------
  // request to the cpu
  // ------------------------------------------------------------------
  // one register stage for every source keeps entry latency constant
  always_ff @(posedge clk) begin
    if (rst) begin
      irqReqQ     <= 1'b0;
      vecNumQ     <= 7'h00;
      newLevelQ   <= 4'h0;
      vectorAddrQ <= RESET_PC;
    end else if (ce) begin
      irqReqQ <= win;
      if (win) begin
        vecNumQ     <= winVec;
        newLevelQ   <= winLevel;
        vectorAddrQ <= tableAddr(winVec, altSelQ);
      end
    end
  end

  assign irqReq     = irqReqQ;
  assign irqVector  = vecNumQ;
  assign irqLevel   = newLevelQ;
  assign vectorAddr = vectorAddrQ;
  assign cpuLevel   = curLevel;

  // ------------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------------
  always_comb begin
    rdData = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == CPU_STATUS_OFS) begin
      rdData[STATUS_LEVEL_LSB +: 3] = levelLowQ;
    end else if (paddr == CORE_CTRL_OFS) begin
      rdData[CORE_TOP_BIT] = levelTopQ;
    end else if (paddr == CTRL1_OFS) begin
      rdData[CTRL1_NEST_BIT]      = nestDisQ;
      rdData[CTRL1_TRAP_LSB +: 4] = trapQ;
    end else if (paddr == CTRL2_OFS) begin
      rdData[CTRL2_ALT_BIT]          = altSelQ;
      rdData[CTRL2_EP_LSB +: NUM_EXT] = edgePolQ;
    end else if (paddr == PENDING_OFS) begin
      rdData[6:0]                = vecNumQ;
      rdData[PEND_LEVEL_LSB +: 4] = newLevelQ;
    end else if (hitRange(paddr, FLAG_BASE, FLAG_WORDS)) begin
      rdData[15:0] = flagQ[wordIdx(paddr, FLAG_BASE)*16 +: 16];
    end else if (hitRange(paddr, ENABLE_BASE, FLAG_WORDS)) begin
      rdData[15:0] = enableQ[wordIdx(paddr, ENABLE_BASE)*16 +: 16];
    end else if (hitRange(paddr, PRIO_BASE, PRIO_WORDS)) begin
      rdData[15:0] = prioQ[wordIdx(paddr, PRIO_BASE)*16 +: 16];
    end else begin
      mapped = 1'b0;
    end
  end

  // sampled in setup so read data and error come from flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdataQ  <= 32'h0000_0000;
      pslverrQ <= 1'b0;
    end else if (setupRd) begin
      prdataQ  <= pwrite ? 32'h0000_0000 : rdData;
      pslverrQ <= !mapped;
    end
  end

  assign prdata  = prdataQ;
  assign pready  = 1'b1;
  assign pslverr = pslverrQ && psel && penable;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence seqTrapSeen;
    trapEvt[0] && ce;
  endsequence

  // software may clear the status bit one cycle after it is set
  sequence seqTrapHeld;
    trapQ[0] ##1 (trapQ[0] || $past(wrEn && paddr == CTRL1_OFS));
  endsequence

  AST_REQ_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    ce |=> irqReq == $past(win))
    else $error("interrupt request does not follow resolver");

  AST_ADDR_DEFAULT: assert property (@(posedge clk) disable iff (rst)
    (ce && win && !altSelQ) |=>
      vectorAddr == 24'(24'h000004 + {16'h0000, irqVector, 1'b0}))
    else $error("default table address wrong");

  AST_ADDR_ALT: assert property (@(posedge clk) disable iff (rst)
    (ce && win && altSelQ) |=>
      vectorAddr == 24'(24'h000104 + {16'h0000, irqVector, 1'b0}))
    else $error("alternate table address wrong");

  AST_TRAP_VECTORS: assert property (@(posedge clk) disable iff (rst)
    (irqReq && irqVector < 7'h08) |->
      (irqVector >= 7'h01 && irqVector <= 7'h04 && irqLevel == 4'(4'hF - irqVector[3:0])))
    else $error("trap vector or level out of range");

  AST_TOP_BLOCKS_USER: assert property (@(posedge clk) disable iff (rst)
    (ce && levelTopQ) |=> !(irqReq && irqVector >= 7'h08))
    else $error("user interrupt passed with top level bit set");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
    !(psel && penable && pwrite && paddr == 12'h040) |=>
      ((flagQ[15:0] & $past(flagQ[15:0])) == $past(flagQ[15:0])))
    else $error("request flag dropped without software write");

  AST_NEST_LOCK: assert property (@(posedge clk) disable iff (rst)
    (nestDisQ && !cpuAck && !cpuReturn) |=> $stable(levelLowQ))
    else $error("status level changed while nesting disabled");

  AST_USER_ABOVE_CPU: assert property (@(posedge clk) disable iff (rst)
    (ce && win && winVec >= 7'h08) |-> (winLevel != 4'h0 && winLevel > curLevel))
    else $error("user source presented at or below cpu level");

  AST_TRAP_STICKS: assert property (@(posedge clk) disable iff (rst)
    seqTrapSeen |=> seqTrapHeld)
    else $error("clock fail trap status not held");

  AST_TOP_NOT_SET_BY_SW: assert property (@(posedge clk) disable iff (rst)
    $rose(levelTopQ) |-> $past(cpuAck) || $past(cpuReturn))
    else $error("top level bit set without cpu entry or return");

endmodule

/* hw/ivc_pkg.sv */
package ivc_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int NUM_SRC    = 78;
  localparam int NUM_TRAP   = 8;
  localparam int NUM_VEC    = 86;
  localparam int FLAG_WORDS = 5;
  localparam int PRIO_WORDS = 20;
  localparam int FLAG_BITS  = FLAG_WORDS * 16;
  localparam int PRIO_BITS  = PRIO_WORDS * 16;
  localparam int NUM_EXT    = 3;
  localparam int TABLE_ENTRIES = 126;

  // ------------------------------------------------------------------
  // apb byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] CPU_STATUS_OFS = 12'h000;
  localparam logic [11:0] CORE_CTRL_OFS  = 12'h004;
  localparam logic [11:0] CTRL1_OFS      = 12'h008;
  localparam logic [11:0] CTRL2_OFS      = 12'h00C;
  localparam logic [11:0] PENDING_OFS    = 12'h010;
  localparam logic [11:0] FLAG_BASE      = 12'h040;
  localparam logic [11:0] ENABLE_BASE    = 12'h060;
  localparam logic [11:0] PRIO_BASE      = 12'h080;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int STATUS_LEVEL_LSB = 5;
  localparam int CORE_TOP_BIT     = 3;
  localparam int CTRL1_NEST_BIT   = 15;
  localparam int CTRL1_TRAP_LSB   = 1;
  localparam int CTRL2_ALT_BIT    = 15;
  localparam int CTRL2_EP_LSB     = 0;
  localparam int PEND_LEVEL_LSB   = 8;
  localparam int PRIO_FIELD_STEP  = 4;

  // ------------------------------------------------------------------
  // vector table layout
  // ------------------------------------------------------------------
  localparam logic [23:0] DEFAULT_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALT_TABLE_OFFSET   = 24'h000100;
  localparam logic [23:0] RESET_PC           = 24'h000000;
  localparam logic [6:0]  FIRST_USER_VEC     = 7'h08;
  localparam logic [3:0]  TRAP_LEVEL_TOP     = 4'hF;

  // trap vectors; trap flag order is osc, stack, address, math
  localparam logic [6:0] VEC_CLOCK_FAIL = 7'h01;
  localparam logic [6:0] VEC_ADDRESS    = 7'h02;
  localparam logic [6:0] VEC_STACK      = 7'h03;
  localparam logic [6:0] VEC_MATH       = 7'h04;

  // request numbers that exist; flag and enable bits of the rest read as zero
  localparam logic [FLAG_BITS-1:0] SRC_IMPL = 80'h2003_C200_0020_381F_3FEF;
  localparam logic [PRIO_BITS-1:0] PRIO_MASK = {PRIO_WORDS{16'h7777}};

  // external inputs feed these request numbers
  localparam int EXT0_SRC = 0;
  localparam int EXT1_SRC = 20;
  localparam int EXT2_SRC = 29;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [2:0]  LEVEL_RESET = 3'h0;

endpackage

/* hw/ivc_resolve.sv */
`timescale 1ns/1ps
module ivc_resolve (
  // candidates
  input  wire logic [ivc_pkg::NUM_VEC-1:0]   pend,
  input  wire logic [ivc_pkg::NUM_VEC*4-1:0] lvl,
  // winner
  output logic                               win,
  output logic [6:0]                         winVec,
  output logic [3:0]                         winLevel
);
  import ivc_pkg::*;

  // ------------------------------------------------------------------
  // level first, then natural order
  // ------------------------------------------------------------------
  // scanning downward with >= lets the lower vector take every tie
  always_comb begin
    win      = 1'b0;
    winVec   = 7'h00;
    winLevel = 4'h0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (pend[v] && (!win || lvl[v*4 +: 4] >= winLevel)) begin
        win      = 1'b1;
        winVec   = 7'(v);
        winLevel = lvl[v*4 +: 4];
      end
    end
  end

endmodule

/* bench/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // controller side
  input  wire logic       irqReq,
  output logic            cpuAck,
  output logic            cpuReturn,
  output logic [3:0]      returnLevel,
  // bench control
  input  wire logic       takeEn,
  input  wire logic [3:0] ackDelay,
  input  wire logic       retReq,
  input  wire logic [3:0] retLvl
);
  logic [3:0] age;
  logic [3:0] hold;

  // ------------------------------------------------------------------
  // take and return
  // ------------------------------------------------------------------
  // hold off after a take: irqReq only drops two edges after the ack
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuAck      <= 1'b0;
      cpuReturn   <= 1'b0;
      returnLevel <= 4'h0;
      age         <= 4'h0;
      hold        <= 4'h0;
    end else begin
      cpuAck      <= 1'b0;
      cpuReturn   <= retReq;
      returnLevel <= retLvl;
      if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end else if (takeEn && irqReq) begin
        if (age == ackDelay) begin
          cpuAck <= 1'b1;
          hold   <= 4'h3;
          age    <= 4'h0;
        end else begin
          age <= age + 4'h1;
        end
      end else begin
        age <= 4'h0;
      end
    end
  end
endmodule

/* bench/test_vectored_interrupt_controller.sv */
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
  import ivc_pkg::*;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [NUM_SRC-1:0] srcReq;
  logic [NUM_EXT-1:0] extPin;
  logic [3:0] trapEvt, returnLevel, irqLevel, cpuLevel, ackDelay, retLvl;
  logic cpuAck, cpuReturn, irqReq, takeEn, retReq;
  logic [6:0] irqVector;
  logic [23:0] vectorAddr;
  int numErrors, checked, k;
  int srcs[6] = '{1, 13, 19, 27, 57, 77};

  vectored_interrupt_controller i_vectored_interrupt_controller (.clk(clk), .rst(rst),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcReq(srcReq), .extPin(extPin), .trapEvt(trapEvt), .cpuAck(cpuAck),
    .cpuReturn(cpuReturn), .returnLevel(returnLevel), .irqReq(irqReq),
    .irqVector(irqVector), .irqLevel(irqLevel), .vectorAddr(vectorAddr),
    .cpuLevel(cpuLevel));
  cpu_core_model i_cpu_core_model (.clk(clk), .rst(rst), .irqReq(irqReq),
    .cpuAck(cpuAck), .cpuReturn(cpuReturn), .returnLevel(returnLevel),
    .takeEn(takeEn), .ackDelay(ackDelay), .retReq(retReq), .retLvl(retLvl));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic giveVerdict;
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer, ends one idle cycle later
  task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] d);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 16'h0000);
    cmp(rdat, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    giveVerdict();
  end

  initial begin
    numErrors = 0; checked = 0;
    rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; srcReq = '0; extPin = '0; trapEvt = 4'h0;
    takeEn = 1'b0; ackDelay = 4'h0; retReq = 1'b0; retLvl = 4'h0;
    tick(16);
    rst <= 1'b0;
    @(posedge clk);
    // ------------------------------------------------------------------
    // reset state and unmapped access
    // ------------------------------------------------------------------
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
    cmp(vectorAddr, 32'h0);
    xfer(12'h0F0, 1'b0, 16'h0000);
    cmp(err, 1'b1);
    // ------------------------------------------------------------------
    // single sources, default and alternate table
    // ------------------------------------------------------------------
    for (int i = 0; i < 6; i++) begin
      k = srcs[i];
      wr(CTRL2_OFS, 16'((i % 2) << 15));
      wr(PRIO_BASE + 12'(4 * (k / 4)), 16'(5 << (4 * (k % 4))));
      wr(ENABLE_BASE + 12'(4 * (k / 16)), 16'(1 << (k % 16)));
      srcReq <= {{(NUM_SRC - 1){1'b0}}, 1'b1} << k;
      @(posedge clk);
      srcReq <= '0;
      @(posedge clk);
      cmp(irqReq, 1'b0);
      @(posedge clk);
      cmp(irqReq, 1'b1);
      cmp(irqVector, 32'(k + 8));
      cmp(vectorAddr, 32'(20 + 2 * k + (i % 2) * 256));
      rd(FLAG_BASE + 12'(4 * (k / 16)), 32'(1 << (k % 16)));
      rd(PENDING_OFS, 32'(1280 + k + 8));
      wr(FLAG_BASE + 12'(4 * (k / 16)), 16'h0000);
      tick(3);
      cmp(irqReq, 1'b0);
      wr(ENABLE_BASE + 12'(4 * (k / 16)), 16'h0000);
    end
    wr(CTRL2_OFS, 16'h0000);
    // ------------------------------------------------------------------
    // priority, cpu level, take and return
    // ------------------------------------------------------------------
    wr(PRIO_BASE, 16'h0330);
    wr(ENABLE_BASE, 16'h0006);
    srcReq <= {{(NUM_SRC - 2){1'b0}}, 2'b11} << 1;
    @(posedge clk);
    srcReq <= '0;
    tick(3);
    cmp(irqVector, 32'h9);
    cmp(irqLevel, 32'h3);
    wr(PRIO_BASE, 16'h0630);
    tick(2);
    cmp(irqVector, 32'hA);
    wr(CPU_STATUS_OFS, 16'h00C0);
    tick(2);
    cmp(irqReq, 1'b0);
    cmp(cpuLevel, 32'h6);
    // trap passes while cpu is at level 6
    trapEvt <= 4'h4;
    @(posedge clk);
    trapEvt <= 4'h0;
    tick(3);
    cmp(irqVector, 32'h2);
    cmp(irqLevel, 32'hD);
    cmp(vectorAddr, 32'h8);
    rd(CTRL1_OFS, 32'h0008);
    ackDelay <= 4'h5;
    takeEn <= 1'b1;
    tick(12);
    takeEn <= 1'b0;
    cmp(cpuLevel, 32'hD);
    rd(CORE_CTRL_OFS, 32'h0008);
    wr(CTRL1_OFS, 16'h0000);
    wr(CPU_STATUS_OFS, 16'h0000);
    tick(2);
    cmp(irqReq, 1'b0);
    wr(CORE_CTRL_OFS, 16'h0000);
    wr(CORE_CTRL_OFS, 16'h0008);
    rd(CORE_CTRL_OFS, 32'h0);
    tick(2);
    cmp(irqVector, 32'hA);
    ackDelay <= 4'h0;
    takeEn <= 1'b1;
    tick(6);
    takeEn <= 1'b0;
    cmp(cpuLevel, 32'h6);
    cmp(irqReq, 1'b0);
    retReq <= 1'b1;
    @(posedge clk);
    retReq <= 1'b0;
    tick(4);
    cmp(cpuLevel, 32'h0);
    cmp(irqReq, 1'b1);
    wr(FLAG_BASE, 16'h0000);
    wr(PRIO_BASE, 16'h0000);
    // ------------------------------------------------------------------
    // nesting lock and edge polarity
    // ------------------------------------------------------------------
    wr(CTRL1_OFS, 16'h8000);
    wr(CPU_STATUS_OFS, 16'h00A0);
    rd(CPU_STATUS_OFS, 32'h0);
    wr(CTRL1_OFS, 16'h0000);
    wr(CTRL2_OFS, 16'h0001);
    extPin <= 3'b001;
    tick(6);
    rd(FLAG_BASE, 32'h0);
    extPin <= 3'b000;
    tick(6);
    rd(FLAG_BASE, 32'h1);
    // positive polarity on input 1 sets request 20
    wr(CTRL2_OFS, 16'h0000);
    extPin <= 3'b010;
    tick(6);
    rd(FLAG_BASE + 12'h004, 32'h0010);
    // clock fail trap: vector 1, status bit 1
    trapEvt <= 4'h1;
    @(posedge clk);
    trapEvt <= 4'h0;
    tick(3);
    cmp(irqVector, 32'h1);
    cmp(vectorAddr, 32'h6);
    rd(CTRL1_OFS, 32'h0002);
    // a math trap while ce is low is lost
    ce <= 1'b0;
    trapEvt <= 4'h8;
    @(posedge clk);
    trapEvt <= 4'h0;
    ce <= 1'b1;
    rd(CTRL1_OFS, 32'h0002);
    // reset in mid-run, pin 1 still high: no false edge
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL1_OFS, 32'h0);
    cmp(vectorAddr, 32'h0);
    cmp(irqReq, 1'b0);
    rd(FLAG_BASE + 12'h004, 32'h0);
    giveVerdict();
  end
endmodule
